// >>> verilog/tiec_top.sv
// Per-thread interrupt, exception and thread-start control.
// Assumes the pipeline presents decode and E2 views of the thread in turn.
`timescale 1ns/1ps
`include "tiec_regs.svh"
module tiec_top
  import tiec_pkg::*;
#(
  parameter int NTHR = 4
) (
  // Clock, enable, reset
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Decode stage view
  input  wire logic [1:0]        d_thr,
  input  wire tiec_pkg::tiec_dec_t d_dec,
  input  wire logic [3:0]        thread_waiting_bits,
  // E2 stage view
  input  wire logic [1:0]        e2_thr,
  input  wire tiec_pkg::tiec_dec_t e2_dec,
  input  wire logic [15:0]       e2_pc,
  input  wire logic [15:0]       e2_addr,
  input  wire logic [15:0]       e2_ra,
  input  wire logic              e2_jump_taken,
  // External interrupt
  input  wire logic              intr,
  input  wire logic [15:0]       isr_addr,
  output logic                   intr_ack,
  // Pipeline controls
  output logic                   pc_load,
  output logic [15:0]            pc_next,
  output logic                   wb_kill,
  output logic                   debug_mode,
  output logic                   r0_load,
  output logic                   halted,
  output logic                   debug_bit,
  output logic [3:0]             active_bits,
  output logic [3:0]             pending_start_bits,
  output tiec_pkg::tiec_cause_t  exception_cause_bits,
  output logic [15:0]            interrupt_return_address,
  output logic [15:0]            isr_capture
);
  // ==========================================================
  // State
  logic [3:0]  mask_ff, nxt_mask;          // Interrupt mask per thread
  logic        ready_ff, nxt_ready;        // Accept-ready from decode
  logic        ack_ff, nxt_ack;            // Acknowledge
  logic [15:0] isr_ff, nxt_isr;            // Captured service address
  logic [15:0] ret_ff [NTHR];              // Return address per thread
  logic [15:0] nxt_ret [NTHR];
  logic        dbg_ff, nxt_dbg;            // Debug register
  logic        dmode_ff, nxt_dmode;        // Debug mode
  logic        pcl_ff, nxt_pcl;
  logic [15:0] pcn_ff, nxt_pcn;
  logic        wbk_ff, nxt_wbk;
  logic        r0_ff, nxt_r0;
  logic        halt_ff, nxt_halt;
  // Slot wiring
  logic [3:0]  act, pend, req_st, do_act, do_kill;
  logic [15:0] paddr [NTHR];
  tiec_cause_t exc_bits;
  logic        exc_any;
  logic        cause_clr;
  tiec_cause_t cause_rd;

  // ==========================================================
  // Thread slots, thread zero boots running
  genvar g;
  generate
    for (g = 0; g < NTHR; g++) begin : g_slot
      tiec_thread_slot #(.BOOT(g == 0)) u_slot (
        .mclk        (mclk),
        .rst         (rst),
        .ce          (ce),
        .req_start   (req_st[g]),
        .start_addr  (e2_ra),
        .do_activate (do_act[g]),
        .do_kill     (do_kill[g]),
        .active      (act[g]),
        .pending     (pend[g]),
        .pend_addr   (paddr[g])
      );
    end
  endgenerate

  // ==========================================================
  // Cause register store
  tiec_cause_store #(.NTHR(NTHR)) u_cause (
    .mclk     (mclk),
    .rst      (rst),
    .ce       (ce),
    .thr      (e2_thr),
    .set_en   (exc_any),
    .set_bits (exc_bits),
    .clr_en   (cause_clr),
    .rd_data  (cause_rd)
  );

  // ==========================================================
  // Exception detection in E2 for the running thread
  always_comb begin
    exc_bits = `TIEC_CAUSE_RESET;
    if (act[e2_thr]) begin
      exc_bits[`TIEC_CAUSE_ILL_INSTR] = e2_dec.bad_opcode
        | (e2_dec.is_rfi & ~mask_ff[e2_thr]);
      exc_bits[`TIEC_CAUSE_UNALIGNED] = e2_addr[0]
        & (e2_dec.is_load | e2_dec.is_store | e2_jump_taken);
      exc_bits[`TIEC_CAUSE_ILL_ADDR] =
        (e2_jump_taken & (e2_addr > `TIEC_PROG_MEM_TOP))
        | (e2_dec.is_store & (e2_addr <= `TIEC_PROG_MEM_TOP));
      exc_bits[`TIEC_CAUSE_ILL_START] = e2_dec.is_start
        & (act[e2_dec.start_tgt] | pend[e2_dec.start_tgt]);
      exc_bits[`TIEC_CAUSE_ILL_WAIT] = e2_dec.is_wait
        & |(e2_dec.wait_mask & ~act);
    end
    exc_any = |exc_bits;
  end

  // ==========================================================
  // Start, activate and kill requests
  always_comb begin
    req_st  = 4'h0;
    do_act  = 4'h0;
    do_kill = 4'h0;
    // Legal start marks the target pending
    if (act[e2_thr] & e2_dec.is_start & ~exc_any) begin
      req_st[e2_dec.start_tgt] = 1'b1;
    end
    // Pending thread wakes on its next E2 slot, one rotation on
    if (pend[e2_thr]) begin
      do_act[e2_thr] = 1'b1;
    end
    // Only own kill or own fault ends a thread
    if (act[e2_thr] & (e2_dec.is_kill | exc_any)) begin
      do_kill[e2_thr] = 1'b1;
    end
    cause_clr = (act[e2_thr] & e2_dec.is_cause_rd)
              | (pend[e2_thr]);
  end

  // ==========================================================
  // Interrupt and PC control, next values
  always_comb begin
    nxt_mask  = mask_ff;
    nxt_ack   = 1'b0;
    nxt_isr   = isr_ff;
    nxt_ret   = ret_ff;
    nxt_dbg   = dbg_ff;
    nxt_dmode = dmode_ff;
    nxt_pcl   = 1'b0;
    nxt_pcn   = pcn_ff;
    nxt_wbk   = 1'b0;
    nxt_r0    = 1'b0;
    // Decode-stage readiness
    nxt_ready = ~d_dec.is_jump & act[d_thr]
              & ~thread_waiting_bits[d_thr] & ~mask_ff[d_thr];
    // Pending thread starts from its stored address
    if (pend[e2_thr]) begin
      nxt_mask[e2_thr] = 1'b0;
      nxt_pcl          = 1'b1;
      nxt_pcn          = paddr[e2_thr];
    end else if (act[e2_thr]) begin
      if (exc_any) begin
        // Fault: no writeback, debug mode, R0 receives save target
        nxt_wbk   = 1'b1;
        nxt_dmode = 1'b1;
        nxt_r0    = 1'b1;
      end else if (ready_ff & intr & ~mask_ff[e2_thr]) begin
        nxt_mask[e2_thr]  = 1'b1;
        nxt_ack           = 1'b1;
        nxt_isr           = isr_addr;
        nxt_ret[e2_thr]   = e2_pc + 16'h0002;
        nxt_pcl           = 1'b1;
        nxt_pcn           = `TIEC_HANDLER_ENTRY;
      end else if (e2_dec.is_rfi) begin
        nxt_mask[e2_thr] = 1'b0;
        nxt_pcl          = 1'b1;
        nxt_pcn          = ret_ff[e2_thr];
      end
      if (e2_dec.is_debug_wr & ~exc_any) begin
        nxt_dbg = e2_dec.debug_imm;
      end
    end
    // Every thread dead and none pending: stop until reset
    nxt_halt = halt_ff | ((act & ~do_kill) == 4'h0
             && (pend | req_st) == 4'h0);
  end

  // ==========================================================
  // Registers; reset is the only way out of a halt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_ff  <= 4'h0;
      ready_ff <= 1'b0;
      ack_ff   <= 1'b0;
      isr_ff   <= 16'h0000;
      for (int i = 0; i < NTHR; i++) begin
        ret_ff[i] <= 16'h0000;
      end
      dbg_ff   <= 1'b0;
      dmode_ff <= 1'b0;
      pcl_ff   <= 1'b0;
      pcn_ff   <= 16'h0000;
      wbk_ff   <= 1'b0;
      r0_ff    <= 1'b0;
      halt_ff  <= 1'b0;
    end else if (ce & ~halt_ff) begin
      mask_ff  <= nxt_mask;
      ready_ff <= nxt_ready;
      ack_ff   <= nxt_ack;
      isr_ff   <= nxt_isr;
      ret_ff   <= nxt_ret;
      dbg_ff   <= nxt_dbg;
      dmode_ff <= nxt_dmode;
      pcl_ff   <= nxt_pcl;
      pcn_ff   <= nxt_pcn;
      wbk_ff   <= nxt_wbk;
      r0_ff    <= nxt_r0;
      halt_ff  <= nxt_halt;
    end
  end

  // Mirrors of registered state for the pipeline
  logic [3:0]  act_ff, pend_ff;
  logic [15:0] retq_ff;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      act_ff  <= `TIEC_ACTIVE_RESET;
      pend_ff <= 4'h0;
      retq_ff <= 16'h0000;
    end else if (ce) begin
      act_ff  <= act;
      pend_ff <= pend;
      retq_ff <= ret_ff[e2_thr];
    end
  end

  assign intr_ack                 = ack_ff;
  assign pc_load                  = pcl_ff;
  assign pc_next                  = pcn_ff;
  assign wb_kill                  = wbk_ff;
  assign debug_mode               = dmode_ff;
  assign r0_load                  = r0_ff;
  assign halted                   = halt_ff;
  assign debug_bit                = dbg_ff;
  assign active_bits              = act_ff;
  assign pending_start_bits       = pend_ff;
  assign exception_cause_bits     = cause_rd;
  assign interrupt_return_address = retq_ff;
  assign isr_capture              = isr_ff;

  // ==========================================================
  // Checks
  a_ack_masked: assert property (@(posedge mclk) disable iff (rst)
    ce && !halt_ff && mask_ff[e2_thr] |=> !intr_ack)
    else $error("ack while masked");
  a_ack_entry: assert property (@(posedge mclk) disable iff (rst)
    intr_ack |-> pc_load && pc_next == `TIEC_HANDLER_ENTRY)
    else $error("ack without handler entry");
  a_ack_cause: assert property (@(posedge mclk) disable iff (rst)
    ce && !halt_ff && nxt_ack |-> intr && ready_ff && !exc_any)
    else $error("ack without cause");
  a_ack_isr: assert property (@(posedge mclk) disable iff (rst)
    ce && !halt_ff && nxt_ack |=> isr_capture == $past(isr_addr))
    else $error("service address not captured");
  a_exc_noack: assert property (@(posedge mclk) disable iff (rst)
    ce && !halt_ff && exc_any && act[e2_thr] |=> !intr_ack && wb_kill)
    else $error("interrupt during exception");
  a_ready_mask: assert property (@(posedge mclk) disable iff (rst)
    ce && !halt_ff && mask_ff[d_thr] |=> !ready_ff)
    else $error("ready while masked");
  a_rfi_clear: assert property (@(posedge mclk) disable iff (rst)
    ce && !halt_ff && act[e2_thr] && e2_dec.is_rfi && !exc_any
    && !nxt_ack |=> mask_ff[$past(e2_thr)] == 1'b0)
    else $error("return did not clear mask");
  a_halt_stays: assert property (@(posedge mclk) disable iff (rst)
    halted |=> halted)
    else $error("halt left without reset");
  c_ack: cover property (@(posedge mclk) disable iff (rst) intr_ack);
  c_exc: cover property (@(posedge mclk) disable iff (rst) wb_kill);
  c_start: cover property (@(posedge mclk) disable iff (rst) |pend);
endmodule

// >>> pkg/tiec_regs.svh
// Constants for the per-thread interrupt and exception control block.
// Included by the top and cause store modules; definitions only.
`ifndef TIEC_REGS_SVH
`define TIEC_REGS_SVH
`define TIEC_HANDLER_ENTRY   16'h0500
`define TIEC_PROG_MEM_TOP    16'h7FFF
`define TIEC_CAUSE_ILL_INSTR 0
`define TIEC_CAUSE_UNALIGNED 1
`define TIEC_CAUSE_ILL_ADDR  2
`define TIEC_CAUSE_ILL_START 3
`define TIEC_CAUSE_ILL_WAIT  4
`define TIEC_CAUSE_RESET     16'h0000
`define TIEC_ACTIVE_RESET    4'h1
`define TIEC_START_MIN_CLK   4
`define TIEC_START_MAX_CLK   7
`endif

// >>> pkg/tiec_pkg.sv
// Types shared by the thread interrupt and exception control block.
// Assumes four interleaved threads and 16-bit addresses.
package tiec_pkg;
  // ==========================================================
  // Decoded instruction from decode stage
  typedef struct packed {
    logic       is_jump;     // Any jump
    logic       is_rfi;      // Return-from-interrupt jump
    logic       is_debug_wr; // Debug-write
    logic       debug_imm;   // Its one-bit operand
    logic       is_start;    // Thread start
    logic [1:0] start_tgt;   // Target thread
    logic       is_kill;     // Kill own thread
    logic       is_load;     // Load
    logic       is_store;    // Store
    logic       is_wait;     // Wait
    logic [3:0] wait_mask;   // Threads waited on
    logic       is_cause_rd; // Read of cause register
    logic       bad_opcode;  // Unrecognised opcode
  } tiec_dec_t;
  // Exception cause snapshot
  typedef logic [15:0] tiec_cause_t;
  // Per-thread slot state
  typedef enum logic [1:0] {
    TIEC_IDLE    = 2'b00,
    TIEC_RUN     = 2'b01,
    TIEC_PENDING = 2'b10
  } tiec_slot_t;
endpackage

// >>> verilog/tiec_cause_store.sv
// Per-thread cause register store, four words, registered read.
// Accepts a write and a clear in one cycle; the written bits are kept.
`timescale 1ns/1ps
`include "tiec_regs.svh"
module tiec_cause_store
  import tiec_pkg::*;
#(
  parameter int NTHR = 4
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Access
  input  wire logic [1:0]       thr,
  input  wire logic             set_en,
  input  wire tiec_pkg::tiec_cause_t set_bits,
  input  wire logic             clr_en,
  output tiec_pkg::tiec_cause_t rd_data
);
  // ==========================================================
  // Storage
  tiec_cause_t mem_ff [NTHR];
  tiec_cause_t nxt_mem [NTHR];
  tiec_cause_t nxt_rd;
  tiec_cause_t rd_ff;
  // Next state; set wins over clear so no event is lost
  always_comb begin
    for (int i = 0; i < NTHR; i++) begin
      nxt_mem[i] = mem_ff[i];
    end
    if (clr_en) begin
      nxt_mem[thr] = `TIEC_CAUSE_RESET;
    end
    if (set_en) begin
      nxt_mem[thr] = (clr_en ? `TIEC_CAUSE_RESET : mem_ff[thr]) | set_bits;
    end
    nxt_rd = mem_ff[thr];
  end
  // Registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NTHR; i++) begin
        mem_ff[i] <= `TIEC_CAUSE_RESET;
      end
      rd_ff <= `TIEC_CAUSE_RESET;
    end else if (ce) begin
      mem_ff <= nxt_mem;
      rd_ff  <= nxt_rd;
    end
  end
  assign rd_data = rd_ff;
endmodule

// >>> verilog/tiec_thread_slot.sv
// One thread's active / pending state and start address.
// Assumes the top only raises req_start when the thread is idle.
`timescale 1ns/1ps
module tiec_thread_slot
  import tiec_pkg::*;
#(
  parameter logic BOOT = 1'b0
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Control
  input  wire logic        req_start,
  input  wire logic [15:0] start_addr,
  input  wire logic        do_activate,
  input  wire logic        do_kill,
  // State
  output logic             active,
  output logic             pending,
  output logic [15:0]      pend_addr
);
  // ==========================================================
  tiec_slot_t  st_ff, nxt_st;
  logic [15:0] addr_ff, nxt_addr;
  // Next state: kill acts only in run; idle and pending ignore it
  always_comb begin
    nxt_st   = st_ff;
    nxt_addr = addr_ff;
    case (st_ff)
      TIEC_IDLE: begin
        if (req_start) begin
          nxt_st   = TIEC_PENDING;
          nxt_addr = start_addr;
        end
      end
      TIEC_PENDING: begin
        if (do_activate) begin
          nxt_st = TIEC_RUN;
        end
      end
      TIEC_RUN: begin
        if (do_kill) begin
          nxt_st = TIEC_IDLE;
        end
      end
      default: nxt_st = TIEC_IDLE;
    endcase
  end
  // Registers; boot thread comes up running
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff   <= BOOT ? TIEC_RUN : TIEC_IDLE;
      addr_ff <= 16'h0000;
    end else if (ce) begin
      st_ff   <= nxt_st;
      addr_ff <= nxt_addr;
    end
  end
  assign active    = (st_ff == TIEC_RUN);
  assign pending   = (st_ff == TIEC_PENDING);
  assign pend_addr = addr_ff;
endmodule

// >>> verification/tiec_intr_src.sv
// Model of the external interrupting device that faces the block.
// Assumes one clock shared with the block; fire is a one-cycle pulse.
`timescale 1ns/1ps
module tiec_intr_src (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Test control
  input  wire logic        fire,
  input  wire logic [15:0] fire_addr,
  // Pins toward the block
  input  wire logic        intr_ack,
  output logic             intr,
  output logic [15:0]      isr_addr
);
  // ==========================================================
  // Request holding
  // Request stands until acknowledge is sampled high; the address
  // is only valid meanwhile, so it is scrambled once released
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      intr     <= 1'b0;
      isr_addr <= 16'hFFFF;
    end else if (fire) begin
      intr     <= 1'b1;
      isr_addr <= fire_addr;
    end else if (intr && intr_ack) begin
      intr     <= 1'b0;
      isr_addr <= ~isr_addr;
    end
  end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the thread interrupt and exception block.
// Assumes the pipeline views are driven by hand, one slot per cycle.
`timescale 1ns/1ps
module tb;
  import tiec_pkg::*;
  // ==========================================================
  // Signals
  logic              mclk, rst, ce, fire, intr, e2_jump_taken;
  logic [1:0]        d_thr, e2_thr;
  tiec_dec_t         d_dec, e2_dec, op;
  logic [3:0]        thread_waiting_bits, active_bits, pending_start_bits;
  logic [15:0]       e2_pc, e2_addr, e2_ra, isr_addr, fire_addr, pc_next;
  logic [15:0]       interrupt_return_address, isr_capture;
  logic              intr_ack, pc_load, wb_kill, debug_mode, r0_load;
  logic              halted, debug_bit;
  tiec_cause_t       exception_cause_bits;
  int                mismatches, comparisons;

  // ==========================================================
  // Instances
  tiec_top tiec_top_inst (.mclk, .rst, .ce, .d_thr, .d_dec,
    .thread_waiting_bits, .e2_thr, .e2_dec, .e2_pc, .e2_addr, .e2_ra,
    .e2_jump_taken, .intr, .isr_addr, .intr_ack, .pc_load, .pc_next,
    .wb_kill, .debug_mode, .r0_load, .halted, .debug_bit, .active_bits,
    .pending_start_bits, .exception_cause_bits,
    .interrupt_return_address, .isr_capture);
  tiec_intr_src tiec_intr_src_inst (.mclk, .rst, .fire, .fire_addr,
    .intr_ack, .intr, .isr_addr);

  // ==========================================================
  // Clock, 5 ns period
  always #2.5 mclk = ~mclk;

  // ==========================================================
  // Shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One pipeline slot: decode and E2 views launched at one edge
  task automatic drive(input logic [1:0] dt, input tiec_dec_t dd,
                       input logic [1:0] et, input tiec_dec_t ed,
                       input logic [15:0] pc, input logic [15:0] av);
    @(posedge mclk);
    d_thr         <= dt;
    d_dec         <= dd;
    e2_thr        <= et;
    e2_dec        <= ed;
    e2_jump_taken <= ed.is_jump;
    e2_pc         <= pc;
    e2_addr       <= av;
    e2_ra         <= av;
  endtask

  // Idle slots on the never-started thread 3
  task automatic idle(input int n);
    repeat (n) drive(2'd3, '0, 2'd3, '0, 16'h0000, 16'h0000);
  endtask

  task automatic fire_intr(input logic [15:0] a);
    @(posedge mclk);
    fire      <= 1'b1;
    fire_addr <= a;
    @(posedge mclk);
    fire      <= 1'b0;
  endtask

  // Thread 0 through decode then E2; acknowledge judged one edge later
  task automatic slot(input tiec_dec_t dd, input logic [15:0] pc,
                      input logic [3:0] ws, input logic exp_ack);
    drive(2'd0, dd, 2'd3, '0, 16'h0000, 16'h0000);
    thread_waiting_bits <= ws;
    drive(2'd1, '0, 2'd0, '0, pc, 16'h0000);
    thread_waiting_bits <= 4'h0;
    idle(1);
    #1;
    check(intr_ack, exp_ack);
    if (exp_ack) begin
      check(pc_next, 16'h0500);
    end
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    check(active_bits, 4'h1);
    check(intr_ack, 1'b0);
    check(halted, 1'b0);
  endtask

  task automatic t_debug;
    // Set then clear, so a stuck register shows either way
    for (int b = 1; b >= 0; b--) begin
      op = '0;
      op.is_debug_wr = 1'b1;
      op.debug_imm = b[0];
      drive(2'd3, '0, 2'd0, op, 16'h0020, 16'h0000);
      idle(1);
      #1;
      check(debug_bit, b[0]);
    end
    // A write offered with the enable low must leave the register alone
    op.debug_imm = 1'b1;
    drive(2'd3, '0, 2'd0, op, 16'h0024, 16'h0000);
    ce <= 1'b0;
    idle(1);
    ce <= 1'b1;
    #1;
    check(debug_bit, 1'b0);
  endtask

  task automatic t_intr;
    fire_intr(16'h9ABC);
    slot('0, 16'h0040, 4'h0, 1'b1);
    check(pc_load, 1'b1);
    check(isr_capture, 16'h9ABC);
    fire_intr(16'h4321);
    slot('0, 16'h0044, 4'h0, 1'b0);
    op = '0;
    op.is_jump = 1'b1;
    op.is_rfi = 1'b1;
    drive(2'd3, '0, 2'd0, op, 16'h0500, 16'h0000);
    idle(1);
    #1;
    check(pc_load, 1'b1);
    check(pc_next, 16'h0042);
    check(interrupt_return_address, 16'h0042);
    op = '0;
    op.is_jump = 1'b1;
    slot(op, 16'h0048, 4'h0, 1'b0);
    slot('0, 16'h0048, 4'h1, 1'b0);
    slot('0, 16'h004C, 4'h0, 1'b1);
    check(isr_capture, 16'h4321);
  endtask

  // Thread 0 starts thread 1, which then faults and is restarted
  task automatic t_start;
    op = '0;
    op.is_start = 1'b1;
    op.start_tgt = 2'd1;
    drive(2'd3, '0, 2'd0, op, 16'h0060, 16'h1234);
    idle(2);
    #1;
    check(pending_start_bits, 4'h2);
    drive(2'd3, '0, 2'd1, '0, 16'h0000, 16'h0000);
    idle(1);
    #1;
    check(pc_load, 1'b1);
    check(pc_next, 16'h1234);
    idle(2);
    #1;
    check(active_bits, 4'h3);
    op.start_tgt = 2'd0;
    drive(2'd3, '0, 2'd1, op, 16'h1234, 16'h0600);
    idle(1);
    #1;
    check(wb_kill, 1'b1);
    check(r0_load, 1'b1);
    check(debug_mode, 1'b1);
    repeat (2) drive(2'd3, '0, 2'd1, '0, 16'h0000, 16'h0000);
    #1;
    check(exception_cause_bits, 16'h0008);
    check(active_bits, 4'h1);
    op.start_tgt = 2'd1;
    drive(2'd3, '0, 2'd0, op, 16'h0062, 16'h2000);
    idle(2);
    repeat (3) drive(2'd3, '0, 2'd1, '0, 16'h0000, 16'h0000);
    #1;
    check(exception_cause_bits, 16'h0000);
    check(active_bits, 4'h3);
  endtask

  // Thread 0 starts thread 1 at 3000 and thread 1 takes its slot
  task automatic restart1;
    tiec_dec_t st;
    st = '0;
    st.is_start = 1'b1;
    st.start_tgt = 2'd1;
    drive(2'd3, '0, 2'd0, st, 16'h0066, 16'h3000);
    idle(1);
    drive(2'd3, '0, 2'd1, '0, 16'h0000, 16'h0000);
    idle(1);
    #1;
    check(pc_load, 1'b1);
    check(pc_next, 16'h3000);
  endtask

  // Thread 1 faults, is found dead with its cause, then is restarted;
  // thread 1 stays in E2 one more slot so the cause read is its own
  task automatic fault1(input tiec_dec_t f, input logic [15:0] av,
                        input logic [15:0] exp);
    drive(2'd3, '0, 2'd1, f, 16'h3000, av);
    drive(2'd3, '0, 2'd1, '0, 16'h0000, 16'h0000);
    #1;
    check(wb_kill, 1'b1);
    check(intr_ack, 1'b0);
    idle(1);
    #1;
    check(exception_cause_bits, exp);
    check(active_bits, 4'h1);
    restart1();
  endtask

  // Every cause but illegal start on thread 1, one fault per restart; the first fault
  // meets a ready thread and a raised interrupt that must go unanswered
  task automatic t_cause;
    fire_intr(16'h5555);
    drive(2'd1, '0, 2'd3, '0, 16'h0000, 16'h0000);
    op = '0;
    op.is_store = 1'b1;
    fault1(op, 16'h0100, 16'h0004);
    op = '0;
    op.is_jump = 1'b1;
    fault1(op, 16'h9001, 16'h0006);
    op = '0;
    op.is_wait = 1'b1;
    op.wait_mask = 4'h4;
    fault1(op, 16'h0000, 16'h0010);
    op = '0;
    op.is_jump = 1'b1;
    op.is_rfi = 1'b1;
    fault1(op, 16'h0000, 16'h0001);
    op = '0;
    op.is_cause_rd = 1'b1;
    op.bad_opcode = 1'b1;
    fault1(op, 16'h0000, 16'h0001);
    // Own kill ends the thread without a fault
    op = '0;
    op.is_kill = 1'b1;
    drive(2'd3, '0, 2'd1, op, 16'h3000, 16'h0000);
    idle(2);
    #1;
    check(active_bits, 4'h1);
    check(wb_kill, 1'b0);
    restart1();
  endtask

  // Faults in both live threads end in a halt
  task automatic t_fault;
    op = '0;
    op.bad_opcode = 1'b1;
    drive(2'd3, '0, 2'd1, op, 16'h2000, 16'h0000);
    repeat (2) drive(2'd3, '0, 2'd1, '0, 16'h0000, 16'h0000);
    #1;
    check(exception_cause_bits, 16'h0001);
    op = '0;
    op.is_load = 1'b1;
    drive(2'd3, '0, 2'd0, op, 16'h0064, 16'h8001);
    repeat (2) drive(2'd3, '0, 2'd0, '0, 16'h0000, 16'h0000);
    #1;
    check(exception_cause_bits, 16'h0002);
    idle(3);
    #1;
    check(active_bits, 4'h0);
    check(halted, 1'b1);
  endtask

  // ==========================================================
  // Verdict, reached from the main flow or the watchdog
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Whole run is about 120 cycles; 20 us leaves ample margin
  initial begin
    #20000;
    mismatches++;
    test_done();
  end

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    fire = 1'b0;
    fire_addr = 16'h0000;
    thread_waiting_bits = 4'h0;
    d_thr = 2'd3;
    e2_thr = 2'd3;
    d_dec = '0;
    e2_dec = '0;
    e2_jump_taken = 1'b0;
    e2_pc = 16'h0000;
    e2_addr = 16'h0000;
    e2_ra = 16'h0000;
    mismatches = 0;
    comparisons = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_debug();
    t_intr();
    t_start();
    t_cause();
    t_fault();
    test_done();
  end
endmodule
